// ==== design/acs_pkg.sv ====
/*
  constants for the conversion sequencer: register offsets, field positions,
  command modes, flag positions, reset values and trigger timing.
  assumes byte addresses on an 8-bit register port with 32-bit data.
*/
package acs_pkg;
  localparam int ACS_ADDR_W = 8;
  localparam int ACS_DATA_W = 32;
  localparam int ACS_CMD_W = 8;
  // register offsets
  localparam logic [7:0] ACS_REG_CMD = 8'h00;
  localparam logic [7:0] ACS_REG_RESULT = 8'h04;
  localparam logic [7:0] ACS_REG_FLAG = 8'h08;
  localparam logic [7:0] ACS_REG_INT_EN = 8'h0c;
  localparam logic [7:0] ACS_REG_TRIG_CTL = 8'h10;
  localparam logic [7:0] ACS_REG_TRIG_CH = 8'h14;
  // command word fields
  localparam int ACS_CMD_MODE_LSB = 0;
  localparam int ACS_CMD_GI_BIT = 2;
  localparam int ACS_CMD_CH_LSB = 4;
  localparam int ACS_RES_CMD_LSB = 16;
  // command modes
  localparam logic [1:0] ACS_MODE_RESET = 2'h0;
  localparam logic [1:0] ACS_MODE_PAUSE = 2'h1;
  localparam logic [1:0] ACS_MODE_TRIG = 2'h2;
  localparam logic [1:0] ACS_MODE_CONT = 2'h3;
  // trigger control fields
  localparam int ACS_TRIG_LEVEL_BIT = 0;
  localparam int ACS_TRIG_POL_BIT = 1;
  localparam int ACS_TRIG_SEL_LSB = 2;
  localparam logic [1:0] ACS_SEL_NONE = 2'h0;
  localparam logic [1:0] ACS_SEL_SYS0 = 2'h1;
  localparam logic [1:0] ACS_SEL_SYS1 = 2'h2;
  localparam logic [1:0] ACS_SEL_ANALOG = 2'h3;
  // flag positions
  localparam int ACS_FLAG_CC = 0;
  localparam int ACS_FLAG_PAUSE = 1;
  localparam int ACS_FLAG_OVERRUN = 2;
  localparam int ACS_FLAG_LOST = 3;
  localparam int ACS_FLAG_CQE = 4;
  localparam int ACS_FLAG_CQF = 5;
  // reset values
  localparam logic [7:0] ACS_CMD_RST = 8'h00;
  localparam logic [3:0] ACS_TRIG_CTL_RST = 4'h0;
  localparam logic [3:0] ACS_TRIG_CH_RST = 4'h0;
  localparam logic [5:0] ACS_INT_EN_RST = 6'h00;
  // trigger edge to conversion start, in clock cycles
  localparam int ACS_TRIG_DELAY = 4;
endpackage

// ==== design/acs_sequencer.sv ====
/*
  conversion sequencer: command queue, conversion, result and fetch state
  machines, trigger selection, flags and register port.
  assumes a converter core that takes conv_start_out, works while
  conv_busy_out is high and pulses conv_done_in with its data.
*/
// Notes on behaviour
// - pause mode converts once, then idles
// - pause completion sets pause flag, maybe interrupts
// - every completion raises result dma request
// - result read cancels result request
// - result request holds until result read
// - running conversion requests next command word
// - continuous completion loads pending or waits
// - unsaved result overwritten sets result-lost flag
// - chaining continues only for trigger/continuous
// - reset command stops conversion, clears queue, returns idle
// - reset command withdraws command fetch request
// - source select 11 routes analog channel
// - level select 0 edge; polarity 1 rising
// - 4-bit field picks trigger analog channel
// - trigger config write stops running conversion
// - trigger mode waits, edge starts conversion
// - conversion starts four cycles after edge
// - extra trigger is ignored, sets overrun in edge mode
// - command write drops fetch request
// - flag read clears sticky flags only
// - all sources share one interrupt output
`timescale 1ns/10ps
module acs_sequencer #(
  parameter int RES_W = 16
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic [acs_pkg::ACS_ADDR_W-1:0] addr_in,
  input wire logic [acs_pkg::ACS_DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [acs_pkg::ACS_DATA_W-1:0] rdata_out,
  input wire logic [15:0] ana_trig_in,
  input wire logic [1:0] sys_trig_in,
  output logic conv_start_out,
  output logic conv_busy_out,
  output logic [3:0] conv_chan_out,
  input wire logic conv_done_in,
  input wire logic [RES_W-1:0] conv_data_in,
  output logic cmd_dma_req_out,
  output logic res_dma_req_out,
  output logic irq_out
);
  import acs_pkg::*;

  typedef enum logic [2:0] {ACS_C_IDLE, ACS_C_WAIT, ACS_C_DELAY, ACS_C_CONV, ACS_C_POST} acs_conv_e;
  typedef enum logic {ACS_F_IDLE, ACS_F_REQ} acs_fetch_e;
  typedef enum logic {ACS_R_IDLE, ACS_R_REQ} acs_res_e;

  if (RES_W < 1 || RES_W > 16)
  begin : g_chk
    $error("RES_W must be 1 to 16");
  end

  function automatic acs_conv_e run_state(input logic [1:0] mode);
    return (mode == ACS_MODE_TRIG) ? ACS_C_WAIT : ACS_C_CONV;
  endfunction

  function automatic logic [1:0] mode_of(input logic [ACS_CMD_W-1:0] cmd);
    return cmd[ACS_CMD_MODE_LSB +: 2];
  endfunction

  acs_conv_e conv_st;
  acs_conv_e next_conv;
  acs_fetch_e fetch_st;
  acs_fetch_e next_fetch;
  acs_res_e res_st;
  acs_res_e next_res;
  logic [ACS_CMD_W-1:0] cur_cmd;
  logic [ACS_CMD_W-1:0] pend_cmd;
  logic pend_valid;
  logic [ACS_CMD_W-1:0] load_val;
  logic load_cur;
  logic wr_used;
  logic pend_used;
  logic [2:0] dly_cnt;
  logic [RES_W-1:0] result_data;
  logic [ACS_CMD_W-1:0] result_cmd;
  logic [3:0] flag_sticky;
  logic [3:0] flag_set;
  logic [3:0] next_sticky;
  logic [5:0] int_en;
  logic [3:0] trig_ctl;
  logic [3:0] trig_ch;
  logic trig_src;
  logic trig_prev;
  logic trig_edge;
  logic trig_fire;
  logic wr_cmd;
  logic wr_reset;
  logic wr_trig;
  logic rd_res;
  logic rd_flag;
  logic done;
  logic [1:0] wmode;
  logic [1:0] cur_mode;
  logic [1:0] trig_sel;

  assign wmode = wdata_in[ACS_CMD_MODE_LSB +: 2];
  assign cur_mode = mode_of(cur_cmd);
  assign wr_cmd = wr_in && addr_in == ACS_REG_CMD;
  assign wr_reset = wr_cmd && wmode == ACS_MODE_RESET;
  assign wr_trig = wr_in && (addr_in == ACS_REG_TRIG_CTL || addr_in == ACS_REG_TRIG_CH);
  assign rd_res = rd_in && addr_in == ACS_REG_RESULT;
  assign rd_flag = rd_in && addr_in == ACS_REG_FLAG;
  assign done = conv_st == ACS_C_CONV && conv_done_in;
  assign trig_sel = trig_ctl[ACS_TRIG_SEL_LSB +: 2];

  // trigger source selection and edge/level qualification
  always_comb
  begin
    unique case (trig_sel)
      ACS_SEL_ANALOG: trig_src = ana_trig_in[trig_ch];
      ACS_SEL_SYS0: trig_src = sys_trig_in[0];
      ACS_SEL_SYS1: trig_src = sys_trig_in[1];
      ACS_SEL_NONE: trig_src = 1'b0;
    endcase
  end

  // a one-cycle pulse is enough since inputs are sampled every cycle
  assign trig_edge = trig_ctl[ACS_TRIG_POL_BIT] ? (trig_src && !trig_prev)
                                                : (!trig_src && trig_prev);
  assign trig_fire = trig_ctl[ACS_TRIG_LEVEL_BIT] ?
                     (trig_src == trig_ctl[ACS_TRIG_POL_BIT]) : trig_edge;

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      trig_prev <= 1'b0;
    else
      trig_prev <= trig_src;
  end

  // conversion state machine
  always_comb
  begin
    next_conv = conv_st;
    load_cur = 1'b0;
    load_val = wdata_in[ACS_CMD_W-1:0];
    wr_used = 1'b0;
    pend_used = 1'b0;
    if (wr_reset)
      next_conv = ACS_C_IDLE;
    else if (wr_trig && conv_st inside {ACS_C_WAIT, ACS_C_DELAY, ACS_C_CONV})
      next_conv = ACS_C_IDLE;
    else
    begin
      unique case (conv_st)
        ACS_C_IDLE:
          if (wr_cmd)
          begin
            next_conv = run_state(wmode);
            load_cur = 1'b1;
            wr_used = 1'b1;
          end
        ACS_C_WAIT:
          if (trig_fire)
            next_conv = ACS_C_DELAY;
        ACS_C_DELAY:
          if (dly_cnt == 3'(ACS_TRIG_DELAY - 1))
            next_conv = ACS_C_CONV;
        ACS_C_CONV:
          if (done)
          begin
            if (cur_mode == ACS_MODE_PAUSE)
              next_conv = ACS_C_IDLE;
            else if (pend_valid)
            begin
              next_conv = run_state(mode_of(pend_cmd));
              load_cur = 1'b1;
              load_val = pend_cmd;
              pend_used = 1'b1;
            end
            else if (wr_cmd)
            begin
              next_conv = run_state(wmode);
              load_cur = 1'b1;
              wr_used = 1'b1;
            end
            else
              next_conv = ACS_C_POST;
          end
        ACS_C_POST:
          if (wr_cmd)
          begin
            next_conv = run_state(wmode);
            load_cur = 1'b1;
            wr_used = 1'b1;
          end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      conv_st <= ACS_C_IDLE;
      conv_start_out <= 1'b0;
      conv_busy_out <= 1'b0;
    end
    else
    begin
      conv_st <= next_conv;
      conv_start_out <= next_conv == ACS_C_CONV && (conv_st != ACS_C_CONV || done);
      conv_busy_out <= next_conv == ACS_C_CONV;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in || conv_st != ACS_C_DELAY)
      dly_cnt <= 3'h1;
    else
      dly_cnt <= dly_cnt + 3'h1;
  end

  // current and pending command words
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      cur_cmd <= ACS_CMD_RST;
    else if (load_cur)
      cur_cmd <= load_val;
  end

  assign conv_chan_out = cur_cmd[ACS_CMD_CH_LSB +: 4];

  // a write during a conversion is queued without touching the running one, except a reset command, which stops it and clears the queue
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in || wr_reset)
    begin
      pend_valid <= 1'b0;
      pend_cmd <= ACS_CMD_RST;
    end
    else if (wr_cmd && !wr_used)
    begin
      pend_valid <= 1'b1;
      pend_cmd <= wdata_in[ACS_CMD_W-1:0];
    end
    else if (pend_used)
      pend_valid <= 1'b0;
  end

  // command fetch state machine
  always_comb
  begin
    next_fetch = fetch_st;
    unique case (fetch_st)
      ACS_F_IDLE:
        if (conv_st == ACS_C_CONV && !pend_valid && !wr_cmd)
          next_fetch = ACS_F_REQ;
      ACS_F_REQ:
        if (wr_cmd)
          next_fetch = ACS_F_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      fetch_st <= ACS_F_IDLE;
      cmd_dma_req_out <= 1'b0;
    end
    else
    begin
      fetch_st <= next_fetch;
      cmd_dma_req_out <= next_fetch == ACS_F_REQ;
    end
  end

  // result state machine; a new completion wins over a same-cycle read
  always_comb
  begin
    next_res = res_st;
    unique case (res_st)
      ACS_R_IDLE:
        if (done)
          next_res = ACS_R_REQ;
      ACS_R_REQ:
        if (!done && rd_res)
          next_res = ACS_R_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      res_st <= ACS_R_IDLE;
      res_dma_req_out <= 1'b0;
    end
    else
    begin
      res_st <= next_res;
      res_dma_req_out <= next_res == ACS_R_REQ;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      result_data <= '0;
      result_cmd <= ACS_CMD_RST;
    end
    else if (done)
    begin
      result_data <= conv_data_in;
      result_cmd <= cur_cmd;
    end
  end

  // sticky flags; a set in the read cycle survives the clear
  always_comb
  begin
    flag_set = 4'h0;
    flag_set[ACS_FLAG_CC] = done && cur_cmd[ACS_CMD_GI_BIT];
    flag_set[ACS_FLAG_PAUSE] = done && cur_mode == ACS_MODE_PAUSE;
    flag_set[ACS_FLAG_OVERRUN] = trig_edge && cur_mode == ACS_MODE_TRIG &&
                                 !trig_ctl[ACS_TRIG_LEVEL_BIT] &&
                                 conv_st inside {ACS_C_DELAY, ACS_C_CONV};
    flag_set[ACS_FLAG_LOST] = done && res_st == ACS_R_REQ && !rd_res;
    next_sticky = (rd_flag ? 4'h0 : flag_sticky) | flag_set;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      flag_sticky <= 4'h0;
      irq_out <= 1'b0;
    end
    else
    begin
      flag_sticky <= next_sticky;
      irq_out <= |({pend_valid && next_conv != ACS_C_IDLE, !pend_valid, next_sticky} &
                   int_en);
    end
  end

  // configuration registers
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      int_en <= ACS_INT_EN_RST;
      trig_ctl <= ACS_TRIG_CTL_RST;
      trig_ch <= ACS_TRIG_CH_RST;
    end
    else if (wr_in)
    begin
      if (addr_in == ACS_REG_INT_EN)
        int_en <= wdata_in[5:0];
      if (addr_in == ACS_REG_TRIG_CTL)
        trig_ctl <= wdata_in[3:0];
      if (addr_in == ACS_REG_TRIG_CH)
        trig_ch <= wdata_in[3:0];
    end
  end

  // read port, data valid the cycle after the strobe
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in || !rd_in)
      rdata_out <= '0;
    else
    begin
      unique case (addr_in)
        ACS_REG_CMD: rdata_out <= 32'(pend_cmd);
        ACS_REG_RESULT: rdata_out <= (32'(result_cmd) << ACS_RES_CMD_LSB) | 32'(result_data);
        ACS_REG_FLAG: rdata_out <= 32'({pend_valid && conv_st != ACS_C_IDLE, !pend_valid,
                                        flag_sticky});
        ACS_REG_INT_EN: rdata_out <= 32'(int_en);
        ACS_REG_TRIG_CTL: rdata_out <= 32'(trig_ctl);
        ACS_REG_TRIG_CH: rdata_out <= 32'(trig_ch);
        default: rdata_out <= '0;
      endcase
    end
  end

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);

  a_pause_idle: assert property (done && cur_mode == ACS_MODE_PAUSE |=>
    conv_st == ACS_C_IDLE && !conv_busy_out) else $error("pause did not idle");
  a_pause_flag: assert property (done && cur_mode == ACS_MODE_PAUSE |=>
    flag_sticky[ACS_FLAG_PAUSE]) else $error("pause flag not set");
  a_res_req_set: assert property (done |=> res_dma_req_out)
    else $error("no result request");
  a_res_read_drop: assert property (res_dma_req_out && rd_res && !done |=>
    !res_dma_req_out) else $error("read did not cancel");
  a_res_req_hold: assert property (res_dma_req_out && !rd_res |=>
    res_dma_req_out) else $error("result request dropped");
  a_fetch_req: assert property (conv_st == ACS_C_CONV && !pend_valid && !wr_cmd |=>
    cmd_dma_req_out) else $error("no fetch request");
  a_chain_load: assert property (done && cur_mode == ACS_MODE_CONT && pend_valid &&
    mode_of(pend_cmd) == ACS_MODE_CONT && !wr_trig && !wr_reset |=> conv_start_out)
    else $error("chain did not start");
  a_post_wait: assert property (done && cur_mode != ACS_MODE_PAUSE && !pend_valid &&
    !wr_cmd && !wr_trig |=> conv_st == ACS_C_POST) else $error("post state missed");
  a_result_lost: assert property (done && res_dma_req_out && !rd_res |=>
    flag_sticky[ACS_FLAG_LOST]) else $error("lost flag not set");
  a_reset_cmd: assert property (wr_reset |=> conv_st == ACS_C_IDLE &&
    !conv_busy_out && !pend_valid) else $error("reset command ignored");
  a_reset_fetch: assert property (wr_reset |=> !cmd_dma_req_out)
    else $error("fetch not withdrawn");
  a_trig_route: assert property (trig_sel == ACS_SEL_ANALOG && conv_st == ACS_C_WAIT &&
    trig_ctl[ACS_TRIG_POL_BIT] && !trig_ctl[ACS_TRIG_LEVEL_BIT] && $stable(trig_ctl) &&
    $stable(trig_ch) && $rose(ana_trig_in[trig_ch]) && !wr_trig && !wr_reset |=>
    conv_st == ACS_C_DELAY) else $error("analog route wrong");
  a_edge_rise: assert property (conv_st == ACS_C_WAIT && trig_ctl == 4'he &&
    trig_src && !trig_prev && !wr_trig && !wr_reset |=> conv_st == ACS_C_DELAY)
    else $error("rising edge missed");
  a_cfg_stop: assert property (wr_trig && conv_st == ACS_C_CONV |=>
    conv_st == ACS_C_IDLE) else $error("config write did not stop");
  a_wait_enter: assert property (conv_st == ACS_C_IDLE && wr_cmd &&
    wmode == ACS_MODE_TRIG && !wr_trig |=> conv_st == ACS_C_WAIT)
    else $error("wait not entered");
  a_trig_delay: assert property (conv_st == ACS_C_WAIT && trig_fire && !wr_trig &&
    !wr_reset ##1 (!wr_trig && !wr_reset)[*3] |=> conv_start_out)
    else $error("start not four cycles after trigger");
  a_overrun: assert property (trig_edge && cur_mode == ACS_MODE_TRIG &&
    !trig_ctl[ACS_TRIG_LEVEL_BIT] && conv_st == ACS_C_CONV && !conv_done_in && !wr_trig &&
    !wr_reset |=> flag_sticky[ACS_FLAG_OVERRUN] && conv_st == ACS_C_CONV && !conv_start_out)
    else $error("overrun mishandled");
  a_fetch_drop: assert property (wr_cmd |=> !cmd_dma_req_out)
    else $error("fetch request stayed");
  a_flag_clear: assert property (rd_flag && flag_set == 4'h0 |=>
    flag_sticky == 4'h0) else $error("flags not cleared");
  a_wait_hold: assert property (conv_st == ACS_C_WAIT && !trig_fire && !wr_trig &&
    !wr_reset |=> conv_st == ACS_C_WAIT) else $error("wait left early");

  c_chain: cover property (done && pend_valid);
  c_trig_start: cover property (conv_st == ACS_C_DELAY ##1 conv_start_out);
  c_lost: cover property (flag_set[ACS_FLAG_LOST]);
  c_reset_wait: cover property (conv_st == ACS_C_WAIT && wr_reset);
endmodule

// ==== test/acs_conv_model.sv ====
/*
  behavioural converter core facing the conversion sequencer.
  assumes start and busy come from the sequencer on the same clock.
*/
`timescale 1ns/10ps
module acs_conv_model #(
  parameter int RES_W = 16
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic conv_start_in,
  input wire logic conv_busy_in,
  input wire logic slow_in,
  input wire logic [RES_W-1:0] sample_in,
  output logic conv_done_out,
  output logic [RES_W-1:0] conv_data_out
);
  int left;
  logic run;

  // data only meaningful beside done; otherwise an inverted pattern
  assign conv_data_out = conv_done_out ? sample_in : ~sample_in;

  always_ff @(posedge sys_clk_in)
  begin
    conv_done_out <= 1'b0;
    if (srst_in)
    begin
      run <= 1'b0;
      left <= 0;
    end
    else if (conv_start_in)
    begin
      run <= 1'b1;
      left <= slow_in ? 24 : 3;
    end
    else if (!conv_busy_in)
      run <= 1'b0;
    else if (run && left == 0)
    begin
      run <= 1'b0;
      conv_done_out <= 1'b1;
    end
    else if (run)
      left <= left - 1;
  end
endmodule

// ==== test/acs_sequencer_tb.sv ====
/*
  self-checking bench for the conversion sequencer: register tasks,
  converter model and trigger pulses. assumes a 25 MHz clock.
*/
`timescale 1ns/10ps
module acs_sequencer_tb;
  import acs_pkg::*;
  localparam logic [31:0] F_DONE = 32'h1 << ACS_FLAG_CC;
  localparam logic [31:0] F_PAUSE = 32'h1 << ACS_FLAG_PAUSE;
  localparam logic [31:0] F_OVR = 32'h1 << ACS_FLAG_OVERRUN;
  localparam logic [31:0] F_LOST = 32'h1 << ACS_FLAG_LOST;
  localparam logic [31:0] F_CQE = 32'h1 << ACS_FLAG_CQE;
  localparam logic [31:0] F_CQF = 32'h1 << ACS_FLAG_CQF;
  localparam logic [31:0] TCTL [3] = '{32'h0e, 32'h06, 32'h0a};
  localparam logic [31:0] TCH [3] = '{32'h7, 32'h0, 32'h0};
  localparam int TBIT [3] = '{7, 16, 17};
  localparam int TDEC [3] = '{6, 17, 16};
  logic sys_clk_in, srst_in, wr_in, rd_in, slow, conv_done_in, irq_out;
  logic conv_start_out, conv_busy_out, cmd_dma_req_out, res_dma_req_out;
  logic [7:0] addr_in;
  logic [31:0] wdata_in, rdata_out, rd_val;
  logic [17:0] trig;
  logic [3:0] conv_chan_out;
  logic [15:0] conv_data_in, sample;
  wire [3:0] ev = {res_dma_req_out, cmd_dma_req_out, ~conv_busy_out, conv_start_out};
  int bad_count, tests_run, n;

  acs_sequencer u_acs_sequencer (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .ana_trig_in(trig[15:0]), .sys_trig_in(trig[17:16]),
    .conv_start_out(conv_start_out), .conv_busy_out(conv_busy_out),
    .conv_chan_out(conv_chan_out), .conv_done_in(conv_done_in),
    .conv_data_in(conv_data_in), .cmd_dma_req_out(cmd_dma_req_out),
    .res_dma_req_out(res_dma_req_out), .irq_out(irq_out));

  acs_conv_model u_acs_conv_model (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .conv_start_in(conv_start_out), .conv_busy_in(conv_busy_out), .slow_in(slow),
    .sample_in(sample), .conv_done_out(conv_done_in), .conv_data_out(conv_data_in));

  initial
  begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge sys_clk_in);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1;
    rd_val = rdata_out;
    chk_word(rd_val, exp);
  endtask

  // 0 start, 1 not busy, 2 fetch request, 3 result request
  task automatic wait_for(input int which);
    for (int i = 0; i < 200; i++)
    begin
      if (ev[which] === 1'b1)
        return;
      idle(1);
    end
    bad_count++;
    $display("unexpected at %0t: wait %h timed out", $time, which);
  endtask

  // one-cycle pulse, the shortest a trigger source may give
  task automatic pulse(input int b);
    @(posedge sys_clk_in);
    trig[b] <= 1'b1;
    @(posedge sys_clk_in);
    trig[b] <= 1'b0;
    #1;
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    #(40 * 20000);
    bad_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    close_out;
  end

  initial
  begin
    srst_in = 1'b1;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 32'h0;
    trig = 18'h0;
    slow = 1'b0;
    sample = 16'h5a3c;
    bad_count = 0;
    tests_run = 0;
    repeat (8) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    idle(1);
    rd_chk(ACS_REG_FLAG, F_CQE);
    rd_chk(ACS_REG_CMD, 32'h0);
    wr(8'h24, 32'hffff_ffff);
    rd_chk(8'h20, 32'h0);
    rd_chk(ACS_REG_FLAG, F_CQE);
    // single convert-and-pause with its interrupt enabled
    wr(ACS_REG_INT_EN, F_PAUSE);
    wr(ACS_REG_CMD, 32'h55);
    chk_bit(conv_start_out, 1'b1);
    chk_word({28'h0, conv_chan_out}, 32'h5);
    wait_for(3);
    idle(10);
    chk_bit(res_dma_req_out, 1'b1);
    chk_bit(conv_busy_out, 1'b0);
    chk_bit(irq_out, 1'b1);
    rd_chk(ACS_REG_FLAG, F_DONE | F_PAUSE | F_CQE);
    idle(2);
    chk_bit(irq_out, 1'b0);
    rd_chk(ACS_REG_FLAG, F_CQE);
    rd_chk(ACS_REG_RESULT, 32'h0055_5a3c);
    chk_bit(res_dma_req_out, 1'b0);
    // chained continuous commands, first result never read
    slow = 1'b1;
    sample = 16'h0123;
    wr(ACS_REG_CMD, 32'h03);
    wait_for(2);
    chk_bit(conv_busy_out, 1'b1);
    wr(ACS_REG_CMD, 32'h13);
    chk_bit(cmd_dma_req_out, 1'b0);
    chk_bit(conv_busy_out, 1'b1);
    rd_chk(ACS_REG_FLAG, F_CQF);
    wait_for(0);
    chk_word({28'h0, conv_chan_out}, 32'h1);
    wait_for(1);
    idle(6);
    chk_bit(conv_busy_out, 1'b0);
    rd_chk(ACS_REG_FLAG, F_LOST | F_CQE);
    rd_chk(ACS_REG_RESULT, 32'h0013_0123);
    wr(ACS_REG_CMD, 32'h01);
    chk_bit(conv_start_out, 1'b1);
    wait_for(1);
    idle(2);
    rd_chk(ACS_REG_RESULT, 32'h0001_0123);
    rd_chk(ACS_REG_FLAG, F_PAUSE | F_CQE);
    // reset command in mid-conversion
    wr(ACS_REG_CMD, 32'h03);
    wait_for(2);
    wr(ACS_REG_CMD, 32'h00);
    chk_bit(conv_busy_out, 1'b0);
    chk_bit(cmd_dma_req_out, 1'b0);
    idle(30);
    chk_bit(res_dma_req_out, 1'b0);
    // analog channel 7, system trigger 0 and 1, all rising edge
    for (int r = 0; r < 3; r++)
    begin
      wr(ACS_REG_TRIG_CTL, TCTL[r]);
      wr(ACS_REG_TRIG_CH, TCH[r]);
      wr(ACS_REG_CMD, 32'h02);
      pulse(TDEC[r]);
      idle(8);
      chk_bit(conv_busy_out, 1'b0);
      pulse(TBIT[r]);
      n = 1;
      while (n < 12 && conv_start_out !== 1'b1)
      begin
        idle(1);
        n++;
      end
      chk_word(n, ACS_TRIG_DELAY);
      idle(4);
      pulse(TBIT[r]);
      chk_bit(conv_busy_out, 1'b1);
      wait_for(1);
      idle(2);
      rd_chk(ACS_REG_FLAG, F_OVR | F_CQE);
      rd_chk(ACS_REG_RESULT, {8'h00, 8'h02, sample});
    end
    // trigger configuration writes abort conversion and wait
    wr(ACS_REG_CMD, 32'h03);
    wr(ACS_REG_TRIG_CH, 32'h7);
    chk_bit(conv_busy_out, 1'b0);
    wr(ACS_REG_CMD, 32'h02);
    wr(ACS_REG_TRIG_CTL, 32'h0e);
    pulse(7);
    idle(8);
    chk_bit(conv_busy_out, 1'b0);
    // reset command while waiting for a trigger
    wr(ACS_REG_CMD, 32'h02);
    wr(ACS_REG_CMD, 32'h00);
    pulse(7);
    idle(8);
    chk_bit(conv_busy_out, 1'b0);
    // level-sensitive wait fires while the trigger stays high
    @(posedge sys_clk_in);
    trig[7] <= 1'b1;
    wr(ACS_REG_TRIG_CTL, 32'h0f);
    wr(ACS_REG_CMD, 32'h02);
    idle(8);
    chk_bit(conv_busy_out, 1'b1);
    close_out;
  end
endmodule
